// ==== rtl/fbsaw_pkg.sv ====
// Summary of operation
// - Watchdog enabled and master silent past monitoring time forces outputs to safe state.
// - Identify as basic cyclic-only slave; offer no configurable alarms.
// - Only station addresses 1 through 125 are valid.
// - Address is ones switch (decimal) plus ten times tens switch (hex).
// - Switches sampled once after power-up; later changes ignored.
// - Decoded value above 125 becomes 126, raises fault, run indicator flashes.
// - Slot 1 accepts 0x71 or 0x72; slot 2 accepts 0x30 or 0x00.
// - Two-word mode exchanges control and speed only; drive ramps apply.
// - On timeout, outputs to drive zeroed and input byte bit 7 cleared.
// - Run indicator flashes when address is zero or above 125.
package fbsaw_pkg;
  localparam logic [7:0] ADDR_MIN        = 8'h01;
  localparam logic [7:0] ADDR_CLAMP_LIM  = 8'h7d;
  localparam logic [7:0] ADDR_MAX        = 8'h7e;
  localparam logic [7:0] CFG_SLOT1_2W    = 8'h71;
  localparam logic [7:0] CFG_SLOT1_3W    = 8'h72;
  localparam logic [7:0] CFG_SLOT2_IO    = 8'h30;
  localparam logic [7:0] CFG_SLOT2_NONE  = 8'h00;
  localparam int         DRIVE_SLAVE_NUM = 1;
  localparam int         READY_BIT       = 7;
  localparam int         CLK_HZ          = 10_000_000;
  localparam int         TICK_US         = 1000;
  localparam int         TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int         FLASH_TICKS     = 250;
  localparam logic [2:0] SAMPLE_DELAY    = 3'h4;
  localparam logic       DPV0_ONLY       = 1'b1;
  localparam logic       ALARMS_OFFERED  = 1'b0;

  typedef struct packed {
    logic [15:0] word1;
    logic [15:0] word2;
    logic [15:0] word3;
    logic [3:0]  dout;
  } fbsaw_pd_out_s;

  typedef enum logic [1:0] {ST_WAIT, ST_RUN, ST_SAFE} fbsaw_wd_e;
endpackage

// ==== rtl/fbsaw_addr_capture.sv ====
`timescale 1ns/1ps
module fbsaw_addr_capture (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [3:0] onesSwitch,
  input  wire logic [3:0] tensSwitch,
  output logic      [7:0] stationAddr,
  output logic            addrFault,
  output logic            addrInvalid,
  output logic            addrValid
);
  logic [2:0] delayCnt, next_delayCnt;
  logic       captured, next_captured;
  logic [7:0] next_stationAddr;
  logic       next_addrFault, next_addrInvalid;
  logic [7:0] raw;

  function automatic logic [7:0] decode(input logic [3:0] ones, input logic [3:0] tens);
    decode = 8'(tens * 8'h0a) + 8'({4'h0, ones});
  endfunction

  always_comb begin
    raw              = decode(onesSwitch, tensSwitch);
    next_delayCnt    = delayCnt;
    next_captured    = captured;
    next_stationAddr = stationAddr;
    next_addrFault   = addrFault;
    next_addrInvalid = addrInvalid;
    if (!captured) begin
      // Settle delay after reset before the one and only sample
      if (delayCnt != fbsaw_pkg::SAMPLE_DELAY) begin
        next_delayCnt = delayCnt + 3'h1;
      end else begin
        next_captured = 1'b1;
        if (raw > fbsaw_pkg::ADDR_CLAMP_LIM) begin
          next_stationAddr = fbsaw_pkg::ADDR_MAX;
          next_addrFault   = 1'b1;
          next_addrInvalid = 1'b1;
        end else begin
          next_stationAddr = raw;
          next_addrInvalid = (raw < fbsaw_pkg::ADDR_MIN);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      delayCnt    <= 3'h0;
      captured    <= 1'b0;
      stationAddr <= 8'h00;
      addrFault   <= 1'b0;
      addrInvalid <= 1'b0;
    end else begin
      delayCnt    <= next_delayCnt;
      captured    <= next_captured;
      stationAddr <= next_stationAddr;
      addrFault   <= next_addrFault;
      addrInvalid <= next_addrInvalid;
    end
  end

  assign addrValid = captured;
endmodule

// ==== rtl/fbsaw_top.sv ====
`timescale 1ns/1ps
module fbsaw_top #(
  parameter int TICK_CYCLES = fbsaw_pkg::TICK_CYCLES,
  parameter int FLASH_TICKS = fbsaw_pkg::FLASH_TICKS
) (
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic [3:0]              onesSwitch,
  input  wire logic [3:0]              tensSwitch,
  input  wire logic                    cfgStrobe,
  input  wire logic [7:0]              cfgSlot1,
  input  wire logic [7:0]              cfgSlot2,
  input  wire logic                    wdEnable,
  input  wire logic [15:0]             wdTimeMs,
  input  wire logic                    dataExchange,
  input  wire fbsaw_pkg::fbsaw_pd_out_s masterOut,
  input  wire logic [7:0]              driveInByte,
  output fbsaw_pkg::fbsaw_pd_out_s      driveOut,
  output logic                         driveWord3Valid,
  output logic                         ioEnabled,
  output logic [7:0]                   masterInByte,
  output logic                         cfgOk,
  output logic                         cfgError,
  output logic [7:0]                   stationAddr,
  output logic                         addrFault,
  output logic                         runLed,
  output logic                         safeState,
  output logic                         dpv0Only,
  output logic                         alarmsOffered
);
  logic addrInvalid, addrValid;

  fbsaw_addr_capture uAddr (
    .mclk        (mclk),
    .resetn      (resetn),
    .onesSwitch  (onesSwitch),
    .tensSwitch  (tensSwitch),
    .stationAddr (stationAddr),
    .addrFault   (addrFault),
    .addrInvalid (addrInvalid),
    .addrValid   (addrValid)
  );

  // Fixed identity: cyclic-only slave, no alarm services
  assign dpv0Only      = fbsaw_pkg::DPV0_ONLY;
  assign alarmsOffered = fbsaw_pkg::ALARMS_OFFERED;

  // Configuration check
  logic cfgThree, next_cfgThree, next_ioEnabled, next_cfgOk, next_cfgError;
  logic slot1Ok, slot2Ok;

  always_comb begin
    slot1Ok        = (cfgSlot1 == fbsaw_pkg::CFG_SLOT1_2W) || (cfgSlot1 == fbsaw_pkg::CFG_SLOT1_3W);
    slot2Ok        = (cfgSlot2 == fbsaw_pkg::CFG_SLOT2_IO) || (cfgSlot2 == fbsaw_pkg::CFG_SLOT2_NONE);
    next_cfgThree  = cfgThree;
    next_ioEnabled = ioEnabled;
    next_cfgOk     = cfgOk;
    next_cfgError  = cfgError;
    if (cfgStrobe) begin
      if (slot1Ok && slot2Ok) begin
        next_cfgOk     = 1'b1;
        next_cfgError  = 1'b0;
        next_cfgThree  = (cfgSlot1 == fbsaw_pkg::CFG_SLOT1_3W);
        next_ioEnabled = (cfgSlot2 == fbsaw_pkg::CFG_SLOT2_IO);
      end else begin
        // A rejected set keeps exchange off rather than guessing a mode
        next_cfgOk    = 1'b0;
        next_cfgError = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfgThree  <= 1'b0;
      ioEnabled <= 1'b0;
      cfgOk     <= 1'b0;
      cfgError  <= 1'b0;
    end else begin
      cfgThree  <= next_cfgThree;
      ioEnabled <= next_ioEnabled;
      cfgOk     <= next_cfgOk;
      cfgError  <= next_cfgError;
    end
  end

  // Millisecond tick, shared by watchdog and flasher
  logic [31:0] tickCnt, next_tickCnt;
  logic        tick;

  always_comb begin
    tick         = (tickCnt == 32'(TICK_CYCLES - 1));
    next_tickCnt = tick ? 32'h0 : tickCnt + 32'h1;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tickCnt <= 32'h0;
    end else begin
      tickCnt <= next_tickCnt;
    end
  end

  // Response watchdog
  fbsaw_pkg::fbsaw_wd_e wdState, next_wdState;
  logic [15:0] wdCnt, next_wdCnt;
  logic        exchangeOk;

  always_comb begin
    exchangeOk   = dataExchange && cfgOk && addrValid;
    next_wdState = wdState;
    next_wdCnt   = wdCnt;
    case (wdState)
      fbsaw_pkg::ST_WAIT: begin
        if (exchangeOk) begin
          next_wdState = fbsaw_pkg::ST_RUN;
          next_wdCnt   = 16'h0;
        end
      end
      fbsaw_pkg::ST_RUN: begin
        if (exchangeOk) begin
          next_wdCnt = 16'h0;
        end else if (wdEnable && tick) begin
          if (wdCnt + 16'h1 >= wdTimeMs) begin
            next_wdState = fbsaw_pkg::ST_SAFE;
          end else begin
            next_wdCnt = wdCnt + 16'h1;
          end
        end
      end
      fbsaw_pkg::ST_SAFE: begin
        if (exchangeOk) begin
          next_wdState = fbsaw_pkg::ST_RUN;
          next_wdCnt   = 16'h0;
        end
      end
      default: next_wdState = fbsaw_pkg::ST_WAIT;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wdState <= fbsaw_pkg::ST_WAIT;
      wdCnt   <= 16'h0;
    end else begin
      wdState <= next_wdState;
      wdCnt   <= next_wdCnt;
    end
  end

  // Process data path; drive outputs zero and ready bit cleared whenever not in ST_RUN
  fbsaw_pkg::fbsaw_pd_out_s next_driveOut;
  logic [7:0] next_masterInByte;
  logic       next_driveWord3Valid, next_safeState;

  always_comb begin
    next_driveOut        = '0;
    next_driveWord3Valid = 1'b0;
    next_safeState       = (wdState != fbsaw_pkg::ST_RUN);
    next_masterInByte    = driveInByte;
    if (wdState == fbsaw_pkg::ST_RUN) begin
      next_driveOut.word1  = masterOut.word1;
      next_driveOut.word2  = masterOut.word2;
      next_driveOut.word3  = cfgThree ? masterOut.word3 : 16'h0;
      next_driveOut.dout   = ioEnabled ? masterOut.dout : 4'h0;
      next_driveWord3Valid = cfgThree;
    end else begin
      next_masterInByte[fbsaw_pkg::READY_BIT] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      driveOut        <= '0;
      driveWord3Valid <= 1'b0;
      safeState       <= 1'b1;
      masterInByte    <= 8'h00;
    end else begin
      driveOut        <= next_driveOut;
      driveWord3Valid <= next_driveWord3Valid;
      safeState       <= next_safeState;
      masterInByte    <= next_masterInByte;
    end
  end

  // Run indicator: steady whenever the address is good, flashing on bad address
  logic [15:0] flashCnt, next_flashCnt;
  logic        flashPhase, next_flashPhase, next_runLed;

  always_comb begin
    next_flashCnt   = flashCnt;
    next_flashPhase = flashPhase;
    if (tick) begin
      if (flashCnt == 16'(FLASH_TICKS - 1)) begin
        next_flashCnt   = 16'h0;
        next_flashPhase = ~flashPhase;
      end else begin
        next_flashCnt = flashCnt + 16'h1;
      end
    end
    next_runLed = (addrInvalid || addrFault) ? flashPhase : 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flashCnt   <= 16'h0;
      flashPhase <= 1'b0;
      runLed     <= 1'b0;
    end else begin
      flashCnt   <= next_flashCnt;
      flashPhase <= next_flashPhase;
      runLed     <= next_runLed;
    end
  end
endmodule

// ==== bench/fbsaw_master_model.sv ====
`timescale 1ns/1ps
module fbsaw_master_model (
  input  wire logic               mclk,
  input  wire logic               active,
  input  wire logic               slow,
  input  wire logic               commission,
  output fbsaw_pkg::fbsaw_pd_out_s masterOut,
  output logic                    dataExchange,
  output logic                    wdEnable
);
  logic                     nextExchange;
  logic                     nextEnable;
  fbsaw_pkg::fbsaw_pd_out_s nextOut;
  initial begin
    masterOut = '0;
    dataExchange = 1'b0;
    wdEnable = 1'b1;
  end
  // Controls taken on the edge, so same-time bench writes cannot race
  always @(posedge mclk) begin
    nextExchange = active & (!slow | 1'($urandom));
    nextEnable = !commission;
    // Idle master data keeps moving, no stale value
    nextOut = active ? 52'({$urandom, $urandom}) : ~masterOut;
    #10;
    dataExchange = nextExchange;
    wdEnable = nextEnable;
    masterOut = nextOut;
  end
endmodule

// ==== bench/fbsaw_top_sva.sv ====
`timescale 1ns/1ps
module fbsaw_top_sva #(
  parameter int TICK_CYCLES = 10,
  parameter int FLASH_TICKS = 2
) (
  input wire logic                     mclk,
  input wire logic                     resetn,
  input wire logic                     cfgStrobe,
  input wire logic [7:0]               cfgSlot1,
  input wire logic [7:0]               cfgSlot2,
  input wire logic                     wdEnable,
  input wire logic [15:0]              wdTimeMs,
  input wire logic                     dataExchange,
  input wire fbsaw_pkg::fbsaw_pd_out_s masterOut,
  input wire fbsaw_pkg::fbsaw_pd_out_s driveOut,
  input wire logic [7:0]               masterInByte,
  input wire logic                     cfgOk,
  input wire logic                     cfgError,
  input wire logic                     ioEnabled,
  input wire logic [7:0]               stationAddr,
  input wire logic                     addrFault,
  input wire logic                     safeState,
  input wire logic                     dpv0Only,
  input wire logic                     alarmsOffered
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [2:0] relCnt;
  int         idleCnt;
  logic       goodCfg;
  logic       ioReq;
  assign goodCfg = (cfgSlot1 == 8'h71 || cfgSlot1 == 8'h72) && (cfgSlot2 == 8'h30 || cfgSlot2 == 8'h00);
  assign ioReq = cfgSlot2 == 8'h30;
  always_ff @(posedge mclk) begin
    relCnt <= !resetn ? 3'h0 : relCnt + 3'(relCnt != 3'h7);
    idleCnt <= (!resetn || dataExchange || !wdEnable) ? 0 : idleCnt + 1;
  end
  sequence s_good; cfgStrobe && goodCfg; endsequence
  sequence s_wake; safeState && dataExchange && cfgOk && !cfgStrobe && relCnt == 3'h7; endsequence
  property p_ident; dpv0Only && !alarmsOffered; endproperty
  property p_clamp; addrFault |-> stationAddr == 8'h7e; endproperty
  property p_hold; relCnt == 3'h7 |-> $stable(stationAddr); endproperty
  property p_safe; safeState |-> driveOut == '0 && !masterInByte[7]; endproperty
  property p_wd; idleCnt > (wdTimeMs + 2) * TICK_CYCLES |-> safeState; endproperty
  property p_pass;
    !safeState && !$past(safeState) |->
      driveOut.word1 == $past(masterOut.word1) && driveOut.word2 == $past(masterOut.word2);
  endproperty
  property p_wake; s_wake |-> ##2 !safeState; endproperty
  property p_cfgOk; s_good |=> cfgOk && !cfgError && ioEnabled == $past(ioReq); endproperty
  property p_cfgBad; cfgStrobe && !goodCfg |=> cfgError && !cfgOk; endproperty
  a_ident: assert property (p_ident) else $error("identity wrong");
  a_clamp: assert property (p_clamp) else $error("clamp wrong");
  a_hold: assert property (p_hold) else $error("address moved");
  a_safe: assert property (p_safe) else $error("safe outputs wrong");
  a_wd: assert property (p_wd) else $error("no timeout");
  a_pass: assert property (p_pass) else $error("speed word lost");
  a_wake: assert property (p_wake) else $error("no resume");
  a_cfgOk: assert property (p_cfgOk) else $error("good config refused");
  a_cfgBad: assert property (p_cfgBad) else $error("bad config taken");
endmodule
bind fbsaw_top fbsaw_top_sva #(.TICK_CYCLES(TICK_CYCLES), .FLASH_TICKS(FLASH_TICKS)) chk_u (
  .mclk          (mclk),
  .resetn        (resetn),
  .cfgStrobe     (cfgStrobe),
  .cfgSlot1      (cfgSlot1),
  .cfgSlot2      (cfgSlot2),
  .wdEnable      (wdEnable),
  .wdTimeMs      (wdTimeMs),
  .dataExchange  (dataExchange),
  .masterOut     (masterOut),
  .driveOut      (driveOut),
  .masterInByte  (masterInByte),
  .cfgOk         (cfgOk),
  .cfgError      (cfgError),
  .ioEnabled     (ioEnabled),
  .stationAddr   (stationAddr),
  .addrFault     (addrFault),
  .safeState     (safeState),
  .dpv0Only      (dpv0Only),
  .alarmsOffered (alarmsOffered)
);

// ==== bench/fbsaw_top_tb.sv ====
`timescale 1ns/1ps
module fbsaw_top_tb;
  logic mclk = 0, resetn = 0, cfgStrobe = 0, active = 0, slow = 0, commission = 0;
  logic [3:0] onesSwitch = 0, tensSwitch = 0;
  logic [7:0] cfgSlot1 = 0, cfgSlot2 = 0, driveInByte = 0, masterInByte, stationAddr;
  logic [15:0] wdTimeMs = 16'h0003;
  logic wdEnable, dataExchange, driveWord3Valid, ioEnabled, cfgOk, cfgError;
  logic addrFault, runLed, safeState, dpv0Only, alarmsOffered;
  logic ioExp = 0;
  logic [7:0] corner[7] = '{8'h01, 8'ha5, 8'hc5, 8'hc6, 8'hc9, 8'hf9, 8'h00};
  fbsaw_pkg::fbsaw_pd_out_s masterOut, driveOut;
  logic [15:0] tbl[12] = '{16'h7100, 16'h7230, 16'h7300, 16'h7131, 16'h0000, 16'h7130,
                           16'h7200, 16'h7030, 16'h0, 16'h0, 16'h0, 16'h7230};
  int n_errors = 0, n_checks = 0, i;
  always #50 mclk = ~mclk;
  fbsaw_top #(.TICK_CYCLES(10), .FLASH_TICKS(2)) dut_u (
    .mclk            (mclk),
    .resetn          (resetn),
    .onesSwitch      (onesSwitch),
    .tensSwitch      (tensSwitch),
    .cfgStrobe       (cfgStrobe),
    .cfgSlot1        (cfgSlot1),
    .cfgSlot2        (cfgSlot2),
    .wdEnable        (wdEnable),
    .wdTimeMs        (wdTimeMs),
    .dataExchange    (dataExchange),
    .masterOut       (masterOut),
    .driveInByte     (driveInByte),
    .driveOut        (driveOut),
    .driveWord3Valid (driveWord3Valid),
    .ioEnabled       (ioEnabled),
    .masterInByte    (masterInByte),
    .cfgOk           (cfgOk),
    .cfgError        (cfgError),
    .stationAddr     (stationAddr),
    .addrFault       (addrFault),
    .runLed          (runLed),
    .safeState       (safeState),
    .dpv0Only        (dpv0Only),
    .alarmsOffered   (alarmsOffered)
  );
  fbsaw_master_model mdl_u (
    .mclk         (mclk),
    .active       (active),
    .slow         (slow),
    .commission   (commission),
    .masterOut    (masterOut),
    .dataExchange (dataExchange),
    .wdEnable     (wdEnable)
  );
  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask
  task finish_test;
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic addrTest(logic [7:0] sw);
    int v, tog;
    logic prev;
    v = sw[3:0] + 10 * sw[7:4];
    resetn = 0;
    onesSwitch = sw[3:0];
    tensSwitch = sw[7:4];
    tick(5);
    resetn = 1;
    tick(8);
    // Later switch moves must not reach the address
    onesSwitch = ~onesSwitch;
    tensSwitch = ~tensSwitch;
    tog = 0;
    prev = runLed;
    repeat (60) begin
      tick(1);
      tog += int'(runLed != prev);
      prev = runLed;
    end
    chk("flash", tog > 0, v == 0 || v > 125);
    chk("addr", stationAddr, v > 125 ? 8'h7e : 8'(v));
    chk("fault", addrFault, v > 125);
  endtask
  task automatic cfg(logic [15:0] s);
    logic good;
    good = (s[15:8] == 8'h71 || s[15:8] == 8'h72) && (s[7:0] == 8'h30 || s[7:0] == 8'h00);
    {cfgSlot1, cfgSlot2} = s;
    cfgStrobe = 1;
    tick(1);
    chk("cfgOk", cfgOk, good);
    chk("cfgErr", cfgError, !good);
    // A refused set must leave the accepted mode alone
    if (good) ioExp = (s[7:0] == 8'h30);
    chk("io", ioEnabled, ioExp);
  endtask
  initial begin
    void'($urandom(49903));
    foreach (tbl[k]) if (tbl[k] == 16'h0 && k > 4) tbl[k] = 16'($urandom);
    foreach (tbl[k]) if (k < 6) addrTest({4'($urandom_range(15)), 4'($urandom_range(9))});
    foreach (corner[k]) addrTest(corner[k]);
    addrTest(8'h12);
    foreach (tbl[k]) cfg(tbl[k]);
    cfgStrobe = 0;
    driveInByte = 8'($urandom) | 8'h80;
    chk("ident", {dpv0Only, alarmsOffered}, 2'b10);
    active = 1;
    slow = 1;
    tick(40);
    chk("run", safeState, 0);
    chk("w3", driveWord3Valid, 1);
    chk("inByte", masterInByte, driveInByte);
    // Steady exchange first, so the last addressing edge is known
    slow = 0;
    tick(2);
    active = 0;
    for (i = 0; i < 60 && safeState !== 1'b1; i++) tick(1);
    chk("early", i >= 20, 1);
    chk("timeout", safeState, 1);
    if (safeState === 1'b1) begin
      chk("zero", driveOut, 0);
      chk("ready", masterInByte, driveInByte & 8'h7f);
      active = 1;
      tick(3);
      chk("resume", safeState, 0);
      cfg(16'h7100);
      cfgStrobe = 0;
      tick(2);
      chk("w3off", {driveWord3Valid, driveOut.word3, driveOut.dout}, 0);
      commission = 1;
      active = 0;
      tick(80);
      chk("noWd", safeState, 0);
    end
    finish_test;
  end
endmodule
